/* ccu_cfg.svh */
// ccu_cfg.svh - offsets, field positions, reset values and codes of the capture/compare unit
// assumes: included by bare name; byte address of an indexed register is its index times four
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH

// =====================================================================
// register indices (byte address = index * 4)
`define CCU_IDX_FLAG      10'h00C
`define CCU_IDX_DIR       10'h086
`define CCU_IDX_CAPL      10'h015
`define CCU_IDX_CAPH      10'h016
`define CCU_IDX_CTRL      10'h017
// port data latch, byte address
`define CCU_ADDR_PORT     12'h100

// =====================================================================
// field positions
`define CCU_FLAG_BIT      2
`define CCU_PIN2_BIT      2
`define CCU_PIN3_BIT      3

// =====================================================================
// reset values
`define CCU_RST_CTRL      8'h00
`define CCU_RST_DIR       8'hFF
`define CCU_RST_PORT      8'h00
`define CCU_RST_CAP       8'h00

// =====================================================================
// mode field codes and prescale wrap points
`define CCU_MODE_OFF      4'h0
`define CCU_MODE_FALL     4'h4
`define CCU_MODE_RISE     4'h5
`define CCU_MODE_CAP4     4'h6
`define CCU_MODE_CAP16    4'h7
`define CCU_MODE_SET      4'h8
`define CCU_MODE_CLR      4'h9
`define CCU_MODE_SOFT     4'hA
`define CCU_MODE_TRIG     4'hB
`define CCU_PSC_LAST4     4'h3
`define CCU_PSC_LAST16    4'hF

// =====================================================================
// bus responses
`define CCU_RESP_OKAY     2'h0
`define CCU_RESP_SLVERR   2'h2

`endif

/* ccu_pkg.sv */
// ccu_pkg.sv - types shared by the capture/compare unit and its bench
// assumes: nothing beyond a SystemVerilog compiler
package ccu_pkg;

    // =================================================================
    // bus carriers
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } ccu_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ccu_axi_rsp_t;

    // =================================================================
    // register selector and unit state
    typedef enum logic [2:0] {
        SEL_NONE, SEL_FLAG, SEL_DIR, SEL_PORT, SEL_CAPL, SEL_CAPH, SEL_CTRL
    } ccu_sel_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] dir;
        logic [7:0] port;
        logic [7:0] cap_l;
        logic [7:0] cap_h;
        logic       flag;
        logic [3:0] psc;
        logic       cmp;
        logic [1:0] duty_lo;
        logic       pin_d;
    } ccu_unit_t;

endpackage

/* ccu_capture_compare.sv */
// ccu_capture_compare.sv - capture/compare unit with AXI4-Lite register slave
// assumes: timer values arrive on I_CLK; pin and strap inputs are asynchronous
//
// Overview of operation
// R1 - mode zero disables and resets the unit; modes 11xx select PWM
// R2 - capture on falling, rising, every 4th or every 16th rising edge
// R3 - compare 1000 drives pin high, 1001 low on match; both set flag
// R4 - compare 1010 only sets the flag on match
// R5 - compare 1011 sets flag, resets timer, starts conversion if enabled
// R6 - control bits 5:4 are PWM duty LSBs, unused otherwise
// R7 - control bits 7:6 read as zero
// R8 - each capture copies the 16-bit timer into the capture pair
// R9 - capture sets flag bit 2; only software clears it
// R10 - a new capture overwrites the old value silently
// R11 - pin driven as output can trigger capture through port writes
// R12 - software keeps the timer synchronous while capturing or comparing
// R13 - software keeps enable clear and clears flag after mode change
// R14 - prescaler cleared whenever unit off or not capturing
// R15 - switching between capture prescales keeps the prescaler count
// R16 - compare every cycle; pin action and flag happen together
// R17 - configuration bit 12 routes the unit pin to pin two or three
// R18 - special trigger resets timer without touching overflow flag
// R19 - writing zero to control forces compare latch low
// R20 - software timer write beats the special trigger reset
// R21 - pin input passes two flip-flops before edge detection
// R22 - prescaler is a 4-bit rising edge counter wrapping at 4 or 16
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ccu_cfg.svh"

module ccu_capture_compare (
    input  wire logic                  I_CLK,
    input  wire logic                  I_RST_B,
    input  wire ccu_pkg::ccu_axi_req_t I_AXI_REQ,
    output ccu_pkg::ccu_axi_rsp_t      O_AXI_RSP,
    input  wire logic [15:0]           I_TIMER_VAL,
    input  wire logic                  I_TMR_WR,
    input  wire logic                  I_ADC_EN,
    input  wire logic [7:0]            I_PWM_BASE,
    input  wire logic [1:0]            I_PWM_FINE,
    input  wire logic                  I_PWM_PEND,
    input  wire logic                  I_PIN_ROUTE,
    input  wire logic                  I_PIN2_IN,
    output logic                       O_PIN2_OUT,
    output logic                       O_PIN2_OE,
    input  wire logic                  I_PIN3_IN,
    output logic                       O_PIN3_OUT,
    output logic                       O_PIN3_OE,
    output logic                       O_TMR_CLR,
    output logic                       O_ADC_GO
);
    import ccu_pkg::*;

    localparam ccu_unit_t UNIT_RST = '{ctrl: `CCU_RST_CTRL, dir: `CCU_RST_DIR, port: `CCU_RST_PORT,
                                       cap_l: `CCU_RST_CAP, cap_h: `CCU_RST_CAP, flag: 1'b0,
                                       psc: 4'h0, cmp: 1'b0, duty_lo: 2'h0, pin_d: 1'b0};

    // =================================================================
    // decode helpers
    function automatic ccu_sel_t decode(input logic [11:0] a);
        ccu_sel_t s;
        s = SEL_NONE;
        if (a == {`CCU_IDX_FLAG, 2'b00}) s = SEL_FLAG;
        else if (a == {`CCU_IDX_DIR, 2'b00}) s = SEL_DIR;
        else if (a == `CCU_ADDR_PORT) s = SEL_PORT;
        else if (a == {`CCU_IDX_CAPL, 2'b00}) s = SEL_CAPL;
        else if (a == {`CCU_IDX_CAPH, 2'b00}) s = SEL_CAPH;
        else if (a == {`CCU_IDX_CTRL, 2'b00}) s = SEL_CTRL;
        return s;
    endfunction

    function automatic logic is_cap(input logic [3:0] m);
        return m[3:2] == 2'b01;
    endfunction

    function automatic logic is_cmp(input logic [3:0] m);
        return m[3:2] == 2'b10;
    endfunction

    function automatic logic is_pwm(input logic [3:0] m);
        return m[3:2] == 2'b11;
    endfunction

    // =================================================================
    // state declarations
    ccu_unit_t   st_ff, nxt_st;
    logic        aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [11:0] aw_addr_ff, nxt_aw_addr;
    logic [7:0]  w_data_ff, nxt_w_data;
    logic        w_strb_ff, nxt_w_strb;
    logic        awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic        bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        pin2_out_ff, nxt_pin2_out, pin2_oe_ff, nxt_pin2_oe;
    logic        pin3_out_ff, nxt_pin3_out, pin3_oe_ff, nxt_pin3_oe;
    logic        tmr_clr_ff, nxt_tmr_clr, adc_go_ff, nxt_adc_go;
    logic        pin2_s1_ff, pin2_s2_ff, pin3_s1_ff, pin3_s2_ff, route_s1_ff, route_s2_ff;
    logic        wr_go, ar_go, cap_evt, match, src, rise, fall;
    logic [3:0]  mode;
    ccu_sel_t    rd_sel, wr_sel;

    // =================================================================
    // pin and strap synchronisers
    // one chain per pad: no logic touches a raw pad, and a route change never meets a half-settled level
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            pin2_s1_ff  <= 1'b0;
            pin2_s2_ff  <= 1'b0;
            pin3_s1_ff  <= 1'b0;
            pin3_s2_ff  <= 1'b0;
            route_s1_ff <= 1'b0;
            route_s2_ff <= 1'b0;
        end else begin
            pin2_s1_ff  <= I_PIN2_IN;   // [R21]
            pin2_s2_ff  <= pin2_s1_ff;  // [R21]
            pin3_s1_ff  <= I_PIN3_IN;   // [R21]
            pin3_s2_ff  <= pin3_s1_ff;  // [R21]
            route_s1_ff <= I_PIN_ROUTE;
            route_s2_ff <= route_s1_ff;
        end
    end

    // =================================================================
    // AXI4-Lite slave: address and data taken in either order, one write and one read at a time
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held  = w_held_ff;
        nxt_w_data  = w_data_ff;
        nxt_w_strb  = w_strb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        wr_sel      = decode(aw_addr_ff);
        rd_sel      = decode(I_AXI_REQ.araddr);
        wr_go       = aw_held_ff && w_held_ff && !bvalid_ff;
        ar_go       = I_AXI_REQ.arvalid && arready_ff;
        if (I_AXI_REQ.awvalid && awready_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = I_AXI_REQ.awaddr;
        end
        if (I_AXI_REQ.wvalid && wready_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_data = I_AXI_REQ.wdata[7:0];   // registers are 8 bits wide, upper lanes ignored
            nxt_w_strb = I_AXI_REQ.wstrb[0];
        end
        if (wr_go) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = (wr_sel == SEL_NONE) ? `CCU_RESP_SLVERR : `CCU_RESP_OKAY;
        end else if (bvalid_ff && I_AXI_REQ.bready) begin
            nxt_bvalid = 1'b0;
        end
        if (ar_go) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = (rd_sel == SEL_NONE) ? `CCU_RESP_SLVERR : `CCU_RESP_OKAY;
            nxt_rdata  = 32'h0;
            unique case (rd_sel)
                SEL_FLAG: nxt_rdata[`CCU_FLAG_BIT] = st_ff.flag;
                SEL_DIR:  nxt_rdata[7:0] = st_ff.dir;
                SEL_PORT: nxt_rdata[7:0] = st_ff.port;
                SEL_CAPL: nxt_rdata[7:0] = st_ff.cap_l;
                SEL_CAPH: nxt_rdata[7:0] = st_ff.cap_h;
                SEL_CTRL: nxt_rdata[7:0] = {2'b00, st_ff.ctrl[5:0]};  // [R7]
                SEL_NONE: nxt_rdata = 32'h0;
            endcase
        end else if (rvalid_ff && I_AXI_REQ.rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready  = !nxt_w_held && !nxt_bvalid;
        nxt_arready = !nxt_rvalid;
    end

    // bus registers
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 12'h000;
            w_held_ff  <= 1'b0;
            w_data_ff  <= 8'h00;
            w_strb_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `CCU_RESP_OKAY;
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `CCU_RESP_OKAY;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff  <= nxt_w_held;
            w_data_ff  <= nxt_w_data;
            w_strb_ff  <= nxt_w_strb;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

    // =================================================================
    // unit core: software writes first, hardware events last so a set beats a clear
    always_comb begin
        nxt_st      = st_ff;
        nxt_tmr_clr = 1'b0;
        nxt_adc_go  = 1'b0;
        mode        = st_ff.ctrl[3:0];
        // an output pin is seen at its own driven level, so port writes can capture
        if (route_s2_ff) src = pin2_oe_ff ? pin2_out_ff : pin2_s2_ff;   // [R11] [R17]
        else             src = pin3_oe_ff ? pin3_out_ff : pin3_s2_ff;   // [R11] [R17]
        rise         = src && !st_ff.pin_d;
        fall         = !src && st_ff.pin_d;
        nxt_st.pin_d = src;
        cap_evt      = 1'b0;
        match        = is_cmp(mode) && ({st_ff.cap_h, st_ff.cap_l} == I_TIMER_VAL);  // [R16]
        // software writes
        if (wr_go && w_strb_ff) begin
            unique case (wr_sel)
                SEL_FLAG: if (w_data_ff[`CCU_FLAG_BIT]) nxt_st.flag = 1'b0;
                SEL_DIR:  nxt_st.dir = w_data_ff;
                SEL_PORT: nxt_st.port = w_data_ff;
                SEL_CAPL: nxt_st.cap_l = w_data_ff;
                SEL_CAPH: if (!is_pwm(mode)) nxt_st.cap_h = w_data_ff;  // read only while modulating
                SEL_CTRL: nxt_st.ctrl = {2'b00, w_data_ff[5:0]};       // [R7]
                SEL_NONE: nxt_st.ctrl = st_ff.ctrl;
            endcase
        end
        // capture prescaler; a change between capture modes keeps the count
        if (is_cap(mode)) begin
            if (rise) begin
                if (mode == `CCU_MODE_CAP4 && st_ff.psc == `CCU_PSC_LAST4) nxt_st.psc = 4'h0;  // [R22]
                else nxt_st.psc = st_ff.psc + 4'h1;                                          // [R22] [R15]
            end
            unique case (mode)
                `CCU_MODE_FALL:  cap_evt = fall;                                  // [R2]
                `CCU_MODE_RISE:  cap_evt = rise;                                  // [R2]
                `CCU_MODE_CAP4:  cap_evt = rise && st_ff.psc == `CCU_PSC_LAST4;   // [R2]
                `CCU_MODE_CAP16: cap_evt = rise && st_ff.psc == `CCU_PSC_LAST16;  // [R2]
            endcase
        end else begin
            nxt_st.psc = 4'h0;  // [R14]
        end
        // PWM: duty double-buffered at period end, pin set unless duty is zero
        if (is_pwm(mode)) begin
            if (I_PWM_PEND) begin
                nxt_st.cap_h   = st_ff.cap_l;
                nxt_st.duty_lo = st_ff.ctrl[5:4];                                   // [R6]
                nxt_st.cmp     = {st_ff.cap_l, st_ff.ctrl[5:4]} != 10'h000;         // [R6]
            end else if ({I_PWM_BASE, I_PWM_FINE} == {st_ff.cap_h, st_ff.duty_lo}) begin
                nxt_st.cmp = 1'b0;
            end
        end
        // compare: pin action and flag in the same cycle
        if (match) begin
            nxt_st.flag = 1'b1;  // [R16]
            unique case (mode)
                `CCU_MODE_SET: nxt_st.cmp = 1'b1;   // [R3]
                `CCU_MODE_CLR: nxt_st.cmp = 1'b0;   // [R3]
                `CCU_MODE_SOFT: nxt_st.cmp = st_ff.cmp;  // [R4]
                `CCU_MODE_TRIG: begin
                    nxt_tmr_clr = !I_TMR_WR;   // [R5] [R20] [R18]
                    nxt_adc_go  = I_ADC_EN;    // [R5]
                end
            endcase
        end
        // capture overwrites any unread value
        if (cap_evt) begin
            {nxt_st.cap_h, nxt_st.cap_l} = I_TIMER_VAL;  // [R8] [R10]
            nxt_st.flag = 1'b1;                          // [R9]
        end
        // mode zero holds the unit in reset and the output latch low
        if (mode == `CCU_MODE_OFF) begin
            nxt_st.cmp = 1'b0;  // [R1] [R19]
            nxt_st.psc = 4'h0;  // [R1]
        end
        // pin drivers: the routed pin carries the unit latch in compare and PWM modes
        nxt_pin2_oe  = !nxt_st.dir[`CCU_PIN2_BIT];
        nxt_pin3_oe  = !nxt_st.dir[`CCU_PIN3_BIT];
        nxt_pin2_out = nxt_st.port[`CCU_PIN2_BIT];
        nxt_pin3_out = nxt_st.port[`CCU_PIN3_BIT];
        if (is_cmp(nxt_st.ctrl[3:0]) || is_pwm(nxt_st.ctrl[3:0])) begin
            if (route_s2_ff) nxt_pin2_out = nxt_st.cmp;  // [R17]
            else             nxt_pin3_out = nxt_st.cmp;  // [R17]
        end
    end

    // unit registers
    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            st_ff       <= UNIT_RST;
            pin2_out_ff <= 1'b0;
            pin2_oe_ff  <= 1'b0;
            pin3_out_ff <= 1'b0;
            pin3_oe_ff  <= 1'b0;
            tmr_clr_ff  <= 1'b0;
            adc_go_ff   <= 1'b0;
        end else begin
            st_ff       <= nxt_st;
            pin2_out_ff <= nxt_pin2_out;
            pin2_oe_ff  <= nxt_pin2_oe;
            pin3_out_ff <= nxt_pin3_out;
            pin3_oe_ff  <= nxt_pin3_oe;
            tmr_clr_ff  <= nxt_tmr_clr;
            adc_go_ff   <= nxt_adc_go;
        end
    end

    // =================================================================
    // outputs, all from flip-flops
    assign O_AXI_RSP  = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff, bresp: bresp_ff,
                          arready: arready_ff, rvalid: rvalid_ff, rdata: rdata_ff, rresp: rresp_ff};
    assign O_PIN2_OUT = pin2_out_ff;
    assign O_PIN2_OE  = pin2_oe_ff;
    assign O_PIN3_OUT = pin3_out_ff;
    assign O_PIN3_OE  = pin3_oe_ff;
    assign O_TMR_CLR  = tmr_clr_ff;
    assign O_ADC_GO   = adc_go_ff;

    // =================================================================
    // checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    sequence s_trig_match;
        match && mode == `CCU_MODE_TRIG && !I_TMR_WR;
    endsequence

    sequence s_trig_done;
        O_TMR_CLR && st_ff.flag;
    endsequence

    capture_copy_a: assert property (cap_evt |=> {st_ff.cap_h, st_ff.cap_l} == $past(I_TIMER_VAL))  // [R8]
        else $error("capture did not copy timer");
    capture_flag_a: assert property (cap_evt |=> st_ff.flag)  // [R9]
        else $error("capture did not set flag");
    ctrl_upper_a: assert property (ar_go && rd_sel == SEL_CTRL |=> O_AXI_RSP.rdata[7:6] == 2'b00)  // [R7]
        else $error("control upper bits read nonzero");
    prescale_clear_a: assert property (!is_cap(mode) |=> st_ff.psc == 4'h0)  // [R14]
        else $error("prescaler not cleared outside capture");
    compare_high_a: assert property (match && mode == `CCU_MODE_SET |=> st_ff.cmp && st_ff.flag)  // [R3]
        else $error("set-on-match failed");
    compare_low_a: assert property (match && mode == `CCU_MODE_CLR |=> !st_ff.cmp && st_ff.flag)  // [R3]
        else $error("clear-on-match failed");
    soft_irq_a: assert property (match && mode == `CCU_MODE_SOFT |=> $stable(st_ff.cmp) && st_ff.flag)  // [R4]
        else $error("soft interrupt changed latch");
    special_event_a: assert property (s_trig_match |=> s_trig_done ##1 !O_TMR_CLR || match)  // [R5]
        else $error("special trigger missing");
    write_first_a: assert property (I_TMR_WR |=> !O_TMR_CLR)  // [R20]
        else $error("timer write lost to trigger");
    mode_off_a: assert property (mode == `CCU_MODE_OFF |=> !st_ff.cmp && st_ff.psc == 4'h0)  // [R1] [R19]
        else $error("unit not reset while off");
    wrap_four_a: assert property (mode == `CCU_MODE_CAP4 && rise && st_ff.psc == 4'h3 |=> st_ff.psc == 4'h0)  // [R22]
        else $error("prescaler did not wrap at four");

endmodule

/* ccu_pin_model.sv */
// ccu_pin_model.sv - far side of the unit pin: an external source seen through the pads
// assumes: the bench sets the source level; resolved pad levels feed the design's pin inputs
`timescale 1ns/1ps

// =====================================================================
// pad resolution: a driven pad reads back its own value, otherwise the source wins
module ccu_pin_model (
    input  wire logic i_lvl,
    input  wire logic i_oe2,
    input  wire logic i_out2,
    input  wire logic i_oe3,
    input  wire logic i_out3,
    output logic      o_pad2,
    output logic      o_pad3
);
    // the unused pad sees the inverse, so a wrong route shows up as a stray capture
    assign o_pad2 = i_oe2 ? i_out2 : i_lvl;
    assign o_pad3 = i_oe3 ? i_out3 : ~i_lvl;
endmodule

/* tb_capture_compare_unit.sv */
// tb_capture_compare_unit.sv - self-checking bench of the capture/compare unit
// assumes: the design, its package and header, and the pin model are compiled first
`timescale 1ns/1ps
`include "ccu_cfg.svh"

module tb_capture_compare_unit;
    import ccu_pkg::*;
    localparam logic [11:0] A_FLAG = {`CCU_IDX_FLAG, 2'h0};
    localparam logic [11:0] A_DIR  = {`CCU_IDX_DIR, 2'h0};
    localparam logic [11:0] A_CAPL = {`CCU_IDX_CAPL, 2'h0};
    localparam logic [11:0] A_CAPH = {`CCU_IDX_CAPH, 2'h0};
    localparam logic [11:0] A_CTRL = {`CCU_IDX_CTRL, 2'h0};
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    ccu_axi_req_t req = '0;
    ccu_axi_rsp_t rsp;
    logic [15:0]  tmr = 16'h0000;
    logic         twr = 1'b0;
    logic         aen = 1'b0;
    logic         lvl = 1'b0;
    logic [7:0]   pbase = 8'h00;
    logic [1:0]   pfine = 2'h0;
    logic         pend = 1'b0;
    logic         pad2, pad3, p2o, p2e, p3o, p3e, tclr, ago;
    logic [1:0]   last_resp;
    logic [7:0]   d;
    logic [3:0]   cm [5] = '{4'h8, 4'hA, 4'h9, 4'hB, 4'hB};
    logic [4:0]   cx [5] = '{5'h0C, 5'h0C, 5'h08, 5'h0B, 5'h10};
    int           failures = 0;
    int           check_count = 0;
    int           cyc = 0;

    // =================================================================
    // clock, timeout, design and far side
    always #20 clk = ~clk;

    // a hang counts as a mismatch and ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end

    ccu_capture_compare dut_u (.I_CLK(clk), .I_RST_B(rst_b), .I_AXI_REQ(req), .O_AXI_RSP(rsp),
        .I_TIMER_VAL(tmr), .I_TMR_WR(twr), .I_ADC_EN(aen), .I_PWM_BASE(pbase), .I_PWM_FINE(pfine),
        .I_PWM_PEND(pend), .I_PIN_ROUTE(1'b1), .I_PIN2_IN(pad2), .O_PIN2_OUT(p2o), .O_PIN2_OE(p2e),
        .I_PIN3_IN(pad3), .O_PIN3_OUT(p3o), .O_PIN3_OE(p3e), .O_TMR_CLR(tclr), .O_ADC_GO(ago));

    ccu_pin_model pin_u (.i_lvl(lvl), .i_oe2(p2e), .i_out2(p2o), .i_oe3(p3e), .i_out3(p3o),
        .o_pad2(pad2), .o_pad3(pad3));

    // =================================================================
    // bus tasks; valid drops at the edge where its ready is sampled high
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        ccu_axi_rsp_t r;
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, v};
        do begin
            @(negedge clk) r = rsp;
            @(posedge clk);
            if (r.awready) req.awvalid <= 1'b0;
            if (r.wready) req.wvalid <= 1'b0;
        end while (!r.bvalid);
        last_resp = r.bresp;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        ccu_axi_rsp_t r;
        req.arvalid <= 1'b1;
        req.araddr <= a;
        do begin
            @(negedge clk) r = rsp;
            @(posedge clk);
            if (r.arready) req.arvalid <= 1'b0;
        end while (!r.rvalid);
        v = r.rdata[7:0];
        last_resp = r.rresp;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic rc(input logic [11:0] a, input logic [7:0] exp);
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp}, "register read");
    endtask

    // one pulse of the pin source, a rising then a falling edge, each followed by time for sync and capture
    task automatic pulse();
        lvl <= 1'b1;
        repeat (4) @(posedge clk);
        lvl <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // timer equals the compare value for exactly one cycle
    task automatic hit(input logic w);
        tmr <= 16'h1234;
        twr <= w;
        @(posedge clk);
        tmr <= 16'h0000;
        twr <= 1'b0;
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // =================================================================
    // main sequence; timer stays synchronous to the clock throughout
    initial begin
        req.bready = 1'b1;
        req.rready = 1'b1;
        req.wstrb = 4'hF;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rc(A_CTRL, 8'h00);
        rc(A_DIR, 8'hFF);
        rc(A_CAPH, 8'h00);
        rd(12'h3FC, d);
        chk({14'h0000, last_resp}, {14'h0000, `CCU_RESP_SLVERR}, "unmapped read");
        wr(A_CTRL, 8'hF5);
        rc(A_CTRL, 8'h35);
        $display("test reset and control done");
        tmr <= 16'hA55A;
        pulse();
        rc(A_CAPL, 8'h5A);
        rc(A_CAPH, 8'hA5);
        rc(A_FLAG, 8'h04);
        tmr <= 16'h1234;
        pulse();
        rc(A_CAPL, 8'h34);
        rc(A_CAPH, 8'h12);
        wr(A_FLAG, 8'h04);
        rc(A_FLAG, 8'h00);
        wr(A_CTRL, 8'h04);
        tmr <= 16'h0F0F;
        lvl <= 1'b1;
        repeat (6) @(posedge clk);
        rc(A_CAPL, 8'h34);
        lvl <= 1'b0;
        repeat (6) @(posedge clk);
        rc(A_CAPL, 8'h0F);
        $display("test edge capture done");
        for (int i = 0; i < 2; i++) begin
            wr(A_CTRL, 8'h00);
            wr(A_CTRL, 8'(6 + i));
            wr(A_FLAG, 8'h04);
            repeat (i ? 15 : 3) pulse();
            rc(A_FLAG, 8'h00);
            pulse();
            rc(A_FLAG, 8'h04);
        end
        $display("test prescaled capture done");
        wr(A_CTRL, 8'h05);
        wr(A_DIR, 8'hFB);
        chk({14'h0000, p2e, p3e}, 16'h0002, "pad enables");
        wr(A_FLAG, 8'h04);
        wr(`CCU_ADDR_PORT, 8'h04);
        repeat (6) @(posedge clk);
        rc(A_FLAG, 8'h04);
        $display("test port driven capture done");
        wr(A_CTRL, 8'h00);
        wr(`CCU_ADDR_PORT, 8'h00);
        wr(A_CAPL, 8'h34);
        wr(A_CAPH, 8'h12);
        for (int i = 0; i < 5; i++) begin
            wr(A_CTRL, {4'h0, cm[i]});
            wr(A_FLAG, 8'h04);
            aen <= cx[i][3];
            hit(cx[i][4]);
            chk({14'h0000, tclr, ago}, {14'h0000, cx[i][1:0]}, "trigger pulses");
            repeat (2) @(posedge clk);
            chk({14'h0000, p3o, p2o}, {15'h0000, cx[i][2]}, "compare pin");
            rc(A_FLAG, 8'h04);
        end
        wr(A_CTRL, 8'h08);
        hit(1'b0);
        wr(A_CTRL, 8'h00);
        wr(A_CTRL, 8'h0A);
        repeat (2) @(posedge clk);
        chk({15'h0000, p2o}, 16'h0000, "latch after disable");
        $display("test compare done");
        wr(A_CAPL, 8'h02);
        wr(A_CTRL, 8'h1C);
        pend <= 1'b1;
        @(posedge clk);
        pend <= 1'b0;
        @(negedge clk);
        chk({15'h0000, p2o}, 16'h0001, "pwm set at period end");
        @(posedge clk);
        pbase <= 8'h02;
        pfine <= 2'h1;
        repeat (2) @(posedge clk);
        #1;
        chk({15'h0000, p2o}, 16'h0000, "pwm clear at duty");
        rc(A_CAPH, 8'h02);
        $display("test pwm done");
        summarize();
    end
endmodule
